// [design/pup_pkg.sv]
// Package: constants, selectors and carriers of the port pull-up and direction block
package pup_pkg;
    // Port geometry
    localparam int          NPORT     = 11;
    localparam int          PW        = 8;
    localparam int          NGRP      = 22;
    localparam int          NPUR      = 3;
    // Values after reset
    localparam logic [7:0]  DIR_RST   = 8'h00;
    localparam logic [7:0]  LATCH_RST = 8'h00;
    localparam logic [7:0]  PUR_RST   = 8'h00;
    localparam logic [7:0]  PUR1_BUS  = 8'h02;
    localparam logic [7:0]  PCR_RST   = 8'h00;
    localparam logic [7:0]  PM0_RST   = 8'h00;
    // Field positions
    localparam int          PU_P4LO   = 1;
    localparam int          PU_P4HI   = 0;
    localparam int          PCR_LATCH = 0;
    localparam int          WRITE_PROTECT_REG_UNLK = 2;
    localparam int          PM0_BCDIS = 7;
    // Processor mode field codes
    localparam logic [1:0]  PM_SINGLE = 2'h0;
    localparam logic [1:0]  PM_EXPAND = 2'h1;
    localparam logic [1:0]  PM_MICRO  = 2'h3;
    // Special ports and lines
    localparam int          P_LATCHRD = 1;
    localparam int          P_GUARD_A = 7;
    localparam int          P_NMI     = 8;
    localparam int          P_GUARD_B = 9;
    localparam logic [7:0]  OD_MASK   = 8'h02;
    localparam logic [7:0]  NMI_MASK  = 8'h20;
    localparam logic [7:0]  LOW_NIB   = 8'h0f;

    // Register selector of the command port
    typedef enum logic [2:0] {
        PUP_SEL_DATA,
        PUP_SEL_DIR,
        PUP_SEL_PULL,
        PUP_SEL_PCR,
        PUP_SEL_WRITE_PROTECT_REG,
        PUP_SEL_PM0
    } pup_sel_t;

    // One register access
    typedef struct packed {
        logic          wr;
        logic          rd;
        pup_sel_t      sel;
        logic [3:0]    idx;
        logic [PW-1:0] wdata;
    } pup_cmd_t;

    // Drive of one port's pads
    typedef struct packed {
        logic [PW-1:0] out;
        logic [PW-1:0] oe;
        logic [PW-1:0] pull;
    } pup_pad_t;

    // Memory expansion or microprocessor mode
    function automatic logic pup_is_bus(input logic [1:0] f);
        return (f == PM_EXPAND) || (f == PM_MICRO);
    endfunction : pup_is_bus
endpackage : pup_pkg

// [design/pup_port_slice.sv]
// Module: one 8-line port with direction bits, port latch, read-back and pad drive
module pup_port_slice (
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     dir_clr,
    // Register writes
    input  wire logic                     dir_we,
    input  wire logic                     data_we,
    input  wire logic [pup_pkg::PW-1:0]   wdata,
    input  wire logic [pup_pkg::PW-1:0]   dir_wmask,
    input  wire logic [pup_pkg::PW-1:0]   data_wmask,
    // Pad configuration
    input  wire logic                     latch_sel,
    input  wire logic [1:0]               grp_pull,
    input  wire logic [pup_pkg::PW-1:0]   pull_ok,
    input  wire logic [pup_pkg::PW-1:0]   od_mask,
    // Pins and state
    input  wire logic [pup_pkg::PW-1:0]   pin_in,
    output logic      [pup_pkg::PW-1:0]   dir,
    output logic      [pup_pkg::PW-1:0]   latch,
    output logic      [pup_pkg::PW-1:0]   rd_val,
    output pup_pkg::pup_pad_t             pad
);
    logic [pup_pkg::PW-1:0] next_dir;
    logic [pup_pkg::PW-1:0] next_latch;

    // Only unmasked bits take a write
    assign next_dir   = dir_we ? ((dir & ~dir_wmask) | (wdata & dir_wmask)) : dir;
    assign next_latch = data_we ? ((latch & ~data_wmask) | (wdata & data_wmask)) : latch;

    // Direction bits, 1 selects output, cleared by every reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir <= pup_pkg::DIR_RST;
        end else if (dir_clr) begin
            dir <= pup_pkg::DIR_RST;
        end else begin
            dir <= next_dir;
        end
    end

    // Port latch is written whatever the direction
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch <= pup_pkg::LATCH_RST;
        end else begin
            latch <= next_latch;
        end
    end

    // Read: pin for inputs, latch for outputs or when latch read-back is chosen
    assign rd_val = latch_sel ? latch : ((dir & latch) | (~dir & pin_in));

    // Pads: open-drain lines only pull low, pull-ups only on inputs
    assign pad.out  = latch & ~od_mask;
    assign pad.oe   = dir & ~(od_mask & latch);
    assign pad.pull = {{4{grp_pull[1]}}, {4{grp_pull[0]}}} & ~dir & pull_ok;
endmodule : pup_port_slice

// [design/pup_port_ctrl.sv]
// Module: port bank with direction, data, pull-up, read-back and bus-mode lockout
module pup_port_ctrl (
    // Clock and resets
    input  wire logic                                      core_clk,
    input  wire logic                                      rst_n,
    input  wire logic                                      soft_rst,
    input  wire logic                                      boot_mode_pin,
    // Register command port
    input  wire pup_pkg::pup_cmd_t                         cmd,
    output logic      [pup_pkg::PW-1:0]                    rd_data,
    output logic                                           rd_valid,
    // Bus controller interface
    input  wire logic [pup_pkg::NPORT-1:0][pup_pkg::PW-1:0] bus_line_mask,
    output logic      [1:0]                                processor_mode_field,
    output logic                                           bus_mode,
    output logic                                           bus_clk_oe,
    // Port pins
    input  wire logic [pup_pkg::NPORT-1:0][pup_pkg::PW-1:0] pin_in,
    output pup_pkg::pup_pad_t [pup_pkg::NPORT-1:0]         pad
);
    // Control registers
    logic [pup_pkg::NPUR-1:0][pup_pkg::PW-1:0]  pull_up_control_reg;
    logic [pup_pkg::PW-1:0]                     port_control_reg;
    logic [pup_pkg::PW-1:0]                     processor_mode_reg0;
    logic                                       direction_write_unlock;
    logic                                       boot_pending;
    // Per-port state from the slices
    logic [pup_pkg::NPORT-1:0][pup_pkg::PW-1:0] port_direction_reg;
    logic [pup_pkg::NPORT-1:0][pup_pkg::PW-1:0] port_data_reg;
    logic [pup_pkg::NPORT-1:0][pup_pkg::PW-1:0] port_rd;
    logic [pup_pkg::NPORT-1:0][pup_pkg::PW-1:0] pull_all;
    // Decoded strobes
    logic                                       wr_dir;
    logic                                       wr_data;
    logic                                       wr_pull;
    logic                                       wr_pcr;
    logic                                       wr_write_protect_reg;
    logic                                       wr_pm0;
    logic                                       port_ok;
    logic                                       auto_p4lo;
    logic [pup_pkg::NGRP-1:0]                   grp;
    logic [pup_pkg::NPUR-1:0][pup_pkg::PW-1:0]  next_pur;
    logic [pup_pkg::PW-1:0]                     next_rd;
    logic [pup_pkg::PW-1:0]                     write_protect_reg_view;

    // Mode and bus clock pin
    assign processor_mode_field = processor_mode_reg0[1:0];
    assign bus_mode   = pup_pkg::pup_is_bus(processor_mode_field);
    assign bus_clk_oe = bus_mode & ~processor_mode_reg0[pup_pkg::PM0_BCDIS];

    // Command decode
    assign port_ok = (cmd.idx < 4'(pup_pkg::NPORT));
    assign wr_dir  = cmd.wr && (cmd.sel == pup_pkg::PUP_SEL_DIR) && port_ok;
    assign wr_data = cmd.wr && (cmd.sel == pup_pkg::PUP_SEL_DATA) && port_ok;
    assign wr_pull = cmd.wr && (cmd.sel == pup_pkg::PUP_SEL_PULL);
    assign wr_pcr  = cmd.wr && (cmd.sel == pup_pkg::PUP_SEL_PCR);
    assign wr_write_protect_reg = cmd.wr && (cmd.sel == pup_pkg::PUP_SEL_WRITE_PROTECT_REG);
    assign wr_pm0  = cmd.wr && (cmd.sel == pup_pkg::PUP_SEL_PM0);

    // Leaving single-chip mode for a bus mode by a write turns on the port 4 low pull bit
    assign auto_p4lo = wr_pm0 && (processor_mode_field == pup_pkg::PM_SINGLE)
                       && pup_pkg::pup_is_bus(cmd.wdata[1:0]);

    // Pull register write, automatic set wins over a same-cycle write
    always_comb begin
        next_pur = pull_up_control_reg;
        if (wr_pull && (cmd.idx < 4'(pup_pkg::NPUR))) begin
            next_pur[cmd.idx[1:0]] = cmd.wdata;
        end
        if (auto_p4lo) begin
            next_pur[1][pup_pkg::PU_P4LO] = 1'b1;
        end
    end

    // Pull-up group map, two groups per port, low nibble first
    assign grp = {pull_up_control_reg[2][5:0],
                  pull_up_control_reg[1][7:2],
                  pull_up_control_reg[1][pup_pkg::PU_P4HI],
                  pull_up_control_reg[1][pup_pkg::PU_P4LO],
                  pull_up_control_reg[0]};

    // Pull-up registers; hardware reset value follows the boot pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_up_control_reg <= '0;
        end else if (boot_pending) begin
            pull_up_control_reg    <= '0;
            pull_up_control_reg[1] <= boot_mode_pin ? pup_pkg::PUR1_BUS
                                                    : pup_pkg::PUR_RST;
        end else if (soft_rst) begin
            pull_up_control_reg    <= '0;
            pull_up_control_reg[1] <= bus_mode ? pup_pkg::PUR1_BUS
                                               : pup_pkg::PUR_RST;
        end else begin
            pull_up_control_reg <= next_pur;
        end
    end

    // Processor mode register; boot pin is caught on the first edge after release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            processor_mode_reg0 <= pup_pkg::PM0_RST;
            boot_pending        <= 1'b1;
        end else if (boot_pending) begin
            processor_mode_reg0 <= {6'h00, boot_mode_pin ? pup_pkg::PM_MICRO
                                                         : pup_pkg::PM_SINGLE};
            boot_pending        <= 1'b0;
        end else if (wr_pm0) begin
            processor_mode_reg0 <= cmd.wdata;
        end
    end

    // Port control and direction unlock; unlock lasts exactly one further write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_control_reg       <= pup_pkg::PCR_RST;
            direction_write_unlock <= 1'b0;
        end else if (soft_rst) begin
            port_control_reg       <= pup_pkg::PCR_RST;
            direction_write_unlock <= 1'b0;
        end else begin
            if (wr_pcr) begin
                port_control_reg <= cmd.wdata;
            end
            if (wr_write_protect_reg) begin
                direction_write_unlock <= cmd.wdata[pup_pkg::WRITE_PROTECT_REG_UNLK];
            end else if (cmd.wr) begin
                direction_write_unlock <= 1'b0;
            end
        end
    end

    // One slice per port
    for (genvar p = 0; p < pup_pkg::NPORT; p++) begin : g_port
        logic [pup_pkg::PW-1:0] lock;
        logic [pup_pkg::PW-1:0] no_dir;
        logic [pup_pkg::PW-1:0] od;
        logic [pup_pkg::PW-1:0] bus_kill;
        logic [pup_pkg::PW-1:0] no_pull;
        logic                   guarded;
        logic                   sel_p;

        // Bus-owned lines are frozen only in bus modes
        assign lock     = bus_mode ? bus_line_mask[p] : '0;
        assign no_dir   = (p == pup_pkg::P_NMI) ? pup_pkg::NMI_MASK : '0;
        assign od       = ((p == pup_pkg::P_GUARD_A) || (p == pup_pkg::P_GUARD_B))
                          ? pup_pkg::OD_MASK : '0;
        assign no_pull  = od | no_dir;
        assign bus_kill = !bus_mode ? '0 :
                          (p < 4 || p == 5) ? 8'hff :
                          (p == 4) ? pup_pkg::LOW_NIB : '0;
        assign guarded  = (p == pup_pkg::P_GUARD_A) || (p == pup_pkg::P_GUARD_B);
        assign sel_p    = (cmd.idx == 4'(p));

        pup_port_slice u_slice (
            .core_clk   (core_clk),
            .rst_n      (rst_n),
            .dir_clr    (soft_rst),
            .dir_we     (wr_dir && sel_p && (!guarded || direction_write_unlock)),
            .data_we    (wr_data && sel_p),
            .wdata      (cmd.wdata),
            .dir_wmask  (~lock & ~no_dir),
            .data_wmask (~lock),
            .latch_sel  ((p == pup_pkg::P_LATCHRD) && port_control_reg[pup_pkg::PCR_LATCH]),
            .grp_pull   (grp[2*p+1 -: 2]),
            .pull_ok    (~bus_kill & ~no_pull),
            .od_mask    (od),
            .pin_in     (pin_in[p]),
            .dir        (port_direction_reg[p]),
            .latch      (port_data_reg[p]),
            .rd_val     (port_rd[p]),
            .pad        (pad[p])
        );

        assign pull_all[p] = pad[p].pull;
    end

    // Read selection
    assign write_protect_reg_view = 8'(direction_write_unlock) << pup_pkg::WRITE_PROTECT_REG_UNLK;
    assign next_rd =
        (cmd.sel == pup_pkg::PUP_SEL_DATA && port_ok) ? port_rd[cmd.idx] :
        (cmd.sel == pup_pkg::PUP_SEL_DIR && port_ok)  ? port_direction_reg[cmd.idx] :
        (cmd.sel == pup_pkg::PUP_SEL_PULL && cmd.idx < 4'(pup_pkg::NPUR))
                                                      ? pull_up_control_reg[cmd.idx[1:0]] :
        (cmd.sel == pup_pkg::PUP_SEL_PCR)             ? port_control_reg :
        (cmd.sel == pup_pkg::PUP_SEL_WRITE_PROTECT_REG)            ? write_protect_reg_view :
        (cmd.sel == pup_pkg::PUP_SEL_PM0)             ? processor_mode_reg0 : '0;

    // Read data register, valid one cycle after the request
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_data  <= cmd.rd ? next_rd : rd_data;
            rd_valid <= cmd.rd;
        end
    end

    // Checks on pad drive and register behaviour
    chk_pull_input_only: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (pull_all & port_direction_reg) == '0)
        else $error("pull-up on an output line");

    chk_no_pull_pins: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !pull_all[7][1] && !pull_all[8][5] && !pull_all[9][1])
        else $error("pull-up on a line without one");

    chk_bus_pull_off: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_mode |-> (pull_all[3:0] == '0) && (pull_all[5] == '0)
                     && (pull_all[4][3:0] == 4'h0))
        else $error("bus port pulled up in bus mode");

    chk_guard_dir_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n || soft_rst)
        wr_dir && (cmd.idx == 4'h7) && !direction_write_unlock
        |=> $stable(port_direction_reg[7]))
        else $error("locked direction register changed");

    chk_unlock_one_shot: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        direction_write_unlock && cmd.wr && !wr_write_protect_reg |=> !direction_write_unlock)
        else $error("direction unlock outlived one write");

    chk_auto_pull_set: assert property (
        @(posedge core_clk) disable iff (!rst_n || soft_rst)
        auto_p4lo |=> pull_up_control_reg[1][pup_pkg::PU_P4LO] && bus_mode)
        else $error("port 4 low pull not set on mode change");

    chk_latch_readback: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cmd.rd && (cmd.sel == pup_pkg::PUP_SEL_DATA) && (cmd.idx == 4'h1)
        && port_control_reg[pup_pkg::PCR_LATCH]
        |=> rd_valid && (rd_data == $past(port_data_reg[1])))
        else $error("port 1 read did not return latch");

    chk_open_drain: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!pad[7].oe[1] || !port_data_reg[7][1]) && (!pad[9].oe[1] || !port_data_reg[9][1])
        && !pad[7].out[1] && !pad[9].out[1])
        else $error("open-drain line driven high");

    chk_bclk_disable: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        processor_mode_reg0[pup_pkg::PM0_BCDIS] |-> !bus_clk_oe)
        else $error("bus clock driven while disabled");

    chk_bus_dir_lock: assert property (
        @(posedge core_clk) disable iff (!rst_n || soft_rst)
        bus_mode && wr_dir && (cmd.idx == 4'h0)
        |=> ((port_direction_reg[0] ^ $past(port_direction_reg[0]))
             & $past(bus_line_mask[0])) == 8'h00)
        else $error("bus line direction changed in bus mode");

    chk_soft_dir_clear: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        soft_rst |=> (port_direction_reg == '0) [*2])
        else $error("direction not cleared by reset");

    // Boot strap capture decides the first mode and pull register 1
    chk_boot_high: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        boot_pending && boot_mode_pin
        |=> (pull_up_control_reg[1] == pup_pkg::PUR1_BUS) && bus_mode)
        else $error("boot high capture wrong");

    chk_boot_low: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        boot_pending && !boot_mode_pin
        |=> (pull_up_control_reg[1] == pup_pkg::PUR_RST) && !bus_mode)
        else $error("boot low capture wrong");

    chk_soft_pull_value: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        soft_rst && !boot_pending
        |=> pull_up_control_reg[1] == ($past(bus_mode) ? pup_pkg::PUR1_BUS : pup_pkg::PUR_RST))
        else $error("pull register 1 wrong after reset");

    chk_dir_readback: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cmd.rd && (cmd.sel == pup_pkg::PUP_SEL_DIR) && port_ok
        |=> rd_valid && (rd_data == $past(port_direction_reg[cmd.idx])))
        else $error("direction read returned wrong value");

    chk_nmi_input_only: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !port_direction_reg[pup_pkg::P_NMI][5] && !pad[pup_pkg::P_NMI].oe[5])
        else $error("input-only line driven");
endmodule : pup_port_ctrl

// [sim/pup_board.sv]
// Board model: resolves every port pin from the chip pad drive and the board drive
module pup_board (
    // Chip side
    input  wire pup_pkg::pup_pad_t [pup_pkg::NPORT-1:0]     pad,
    // Board drive
    input  wire logic [pup_pkg::NPORT-1:0][pup_pkg::PW-1:0] drv,
    // Pin levels
    output logic      [pup_pkg::NPORT-1:0][pup_pkg::PW-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Chip output wins; the board drives only lines that the chip leaves released
    always_comb begin
        for (int p = 0; p < pup_pkg::NPORT; p++) begin
            pin[p] = (pad[p].oe & pad[p].out) | (~pad[p].oe & drv[p]);
        end
    end
endmodule : pup_board

// [sim/tb_pup_port_ctrl.sv]
// Testbench: port bank checked against a behavioural register model
module tb_pup_port_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic                                       core_clk, rst_n, soft_rst, boot_mode_pin;
    logic                                       rd_valid, bus_mode, bus_clk_oe;
    logic [1:0]                                 processor_mode_field;
    logic [7:0]                                 rd_data, m_pcr, m_pm0;
    logic [7:0]                                 m_dir [11];
    logic [7:0]                                 m_lat [11];
    logic [7:0]                                 m_pur [3];
    logic                                       m_unlk;
    logic [31:0]                                seed;
    logic [pup_pkg::NPORT-1:0][pup_pkg::PW-1:0] bus_line_mask, pin_in, drv;
    pup_pkg::pup_pad_t [pup_pkg::NPORT-1:0]     pad;
    pup_pkg::pup_cmd_t                          cmd;
    int                                         fail_count, n_tests;

    // Device and board
    pup_port_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .soft_rst(soft_rst),
        .boot_mode_pin(boot_mode_pin), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid),
        .bus_line_mask(bus_line_mask), .processor_mode_field(processor_mode_field),
        .bus_mode(bus_mode), .bus_clk_oe(bus_clk_oe), .pin_in(pin_in), .pad(pad));
    pup_board u_board (.pad(pad), .drv(drv), .pin(pin_in));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Random source
    function automatic logic [7:0] r8();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : r8

    function automatic logic m_bus();
        return (m_pm0[1:0] == 2'h1) || (m_pm0[1:0] == 2'h3);
    endfunction : m_bus

    // Expected data read: latch on output lines or with read-back select, else pin
    function automatic logic [7:0] exp_data(input int i);
        logic [7:0] s;
        s = (i == 1 && m_pcr[0]) ? 8'hff : m_dir[i];
        return (m_lat[i] & s) | (pin_in[i] & ~s);
    endfunction : exp_data

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // Compare all pads with the model: group pull, input only, fixed no-pull lines, open drain
    task automatic chk_pads();
        int r, lo, hi;
        logic [7:0] g, od, np, kill;
        for (int p = 0; p < 11; p++) begin
            r = p < 4 ? 0 : (p < 8 ? 1 : 2);
            lo = p < 4 ? 2 * p : (p == 4 ? 1 : (p < 8 ? 2 * p - 8 : 2 * p - 16));
            hi = p == 4 ? 0 : lo + 1;
            g = {{4{m_pur[r][hi]}}, {4{m_pur[r][lo]}}};
            od = (p == 7 || p == 9) ? 8'h02 : 8'h00;
            np = od | (p == 8 ? 8'h20 : 8'h00);
            kill = !m_bus() ? 8'h00 : (p < 4 || p == 5) ? 8'hff : (p == 4 ? 8'h0f : 8'h00);
            check({pad[p].out, pad[p].oe, pad[p].pull}, {m_lat[p] & ~od, m_dir[p] & ~(od & m_lat[p]),
                g & ~m_dir[p] & ~np & ~kill});
        end
    endtask : chk_pads

    task automatic mode_chk();
        check({processor_mode_field, bus_mode, bus_clk_oe},
            {m_pm0[1:0], m_bus(), m_bus() & ~m_pm0[7]});
    endtask : mode_chk

    // One write access, mirrored in the model
    task automatic wr(input pup_pkg::pup_sel_t s, input int i, input logic [7:0] d);
        logic [7:0] lk;
        @(negedge core_clk);
        cmd = '{wr: 1'b1, rd: 1'b0, sel: s, idx: i[3:0], wdata: d};
        lk = m_bus() ? bus_line_mask[i] : 8'h00;
        case (s)
            pup_pkg::PUP_SEL_DATA: m_lat[i] = (m_lat[i] & lk) | (d & ~lk);
            pup_pkg::PUP_SEL_DIR: if ((i != 7 && i != 9) || m_unlk)
                m_dir[i] = ((m_dir[i] & lk) | (d & ~lk)) & (i == 8 ? 8'hdf : 8'hff);
            pup_pkg::PUP_SEL_PULL: m_pur[i] = d;
            pup_pkg::PUP_SEL_PCR: m_pcr = d;
            pup_pkg::PUP_SEL_PM0: begin
                if (!m_bus() && (d[1:0] == 2'h1 || d[1:0] == 2'h3)) m_pur[1][1] = 1'b1;
                m_pm0 = d;
            end
            default: ;
        endcase
        m_unlk = (s == pup_pkg::PUP_SEL_WRITE_PROTECT_REG) && d[2];
        @(negedge core_clk);
        cmd.wr = 1'b0;
        chk_pads();
    endtask : wr

    task automatic rd(input pup_pkg::pup_sel_t s, input int i, input logic [7:0] e);
        @(negedge core_clk);
        cmd = '{wr: 1'b0, rd: 1'b1, sel: s, idx: i[3:0], wdata: 8'h00};
        @(negedge core_clk);
        cmd.rd = 1'b0;
        check({rd_valid, rd_data}, {1'b1, e});
    endtask : rd

    task automatic hw(input logic b);
        @(negedge core_clk);
        rst_n = 1'b0;
        boot_mode_pin = b;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        for (int p = 0; p < 11; p++) begin
            m_dir[p] = 8'h00;
            m_lat[p] = 8'h00;
        end
        m_pur = '{8'h00, b ? 8'h02 : 8'h00, 8'h00};
        m_pm0 = b ? 8'h03 : 8'h00;
        m_pcr = 8'h00;
        m_unlk = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : hw

    task automatic srst();
        @(negedge core_clk);
        soft_rst = 1'b1;
        @(negedge core_clk);
        soft_rst = 1'b0;
        for (int p = 0; p < 11; p++) m_dir[p] = 8'h00;
        m_pur = '{8'h00, m_bus() ? 8'h02 : 8'h00, 8'h00};
        m_pcr = 8'h00;
        m_unlk = 1'b0;
        chk_pads();
    endtask : srst

    // Watchdog
    initial begin
        #100000;
        fail_count++;
        results();
    end

    // Main sequence
    initial begin
        cmd = '0;
        rst_n = 1'b0;
        soft_rst = 1'b0;
        boot_mode_pin = 1'b0;
        bus_line_mask = '0;
        drv = '0;
        seed = 32'h3323;
        fail_count = 0;
        n_tests = 0;
        hw(1'b0);
        mode_chk();
        rd(pup_pkg::PUP_SEL_PULL, 1, 8'h00);
        for (int p = 0; p < 11; p++) begin
            drv[p] = r8();
            rd(pup_pkg::PUP_SEL_DIR, p, 8'h00);
        end
        // Direction, data and pull-up groups on every port
        for (int p = 0; p < 11; p++) begin
            wr(pup_pkg::PUP_SEL_DIR, p, r8());
            wr(pup_pkg::PUP_SEL_DATA, p, r8());
            rd(pup_pkg::PUP_SEL_DATA, p, exp_data(p));
        end
        for (int r = 0; r < 3; r++) wr(pup_pkg::PUP_SEL_PULL, r, 8'hff);
        wr(pup_pkg::PUP_SEL_PCR, 0, 8'h01);
        rd(pup_pkg::PUP_SEL_PCR, 0, m_pcr);
        rd(pup_pkg::PUP_SEL_DATA, 1, exp_data(1));
        // Guarded direction registers: blocked, unlocked, unlock lost
        wr(pup_pkg::PUP_SEL_DIR, 7, 8'hff);
        wr(pup_pkg::PUP_SEL_WRITE_PROTECT_REG, 0, 8'h04);
        wr(pup_pkg::PUP_SEL_DIR, 7, 8'h03);
        wr(pup_pkg::PUP_SEL_WRITE_PROTECT_REG, 0, 8'h04);
        rd(pup_pkg::PUP_SEL_WRITE_PROTECT_REG, 0, 8'h04);
        wr(pup_pkg::PUP_SEL_DATA, 0, 8'h5a);
        wr(pup_pkg::PUP_SEL_DIR, 9, 8'hff);
        wr(pup_pkg::PUP_SEL_WRITE_PROTECT_REG, 0, 8'h04);
        wr(pup_pkg::PUP_SEL_DIR, 9, 8'h02);
        rd(pup_pkg::PUP_SEL_DIR, 7, m_dir[7]);
        rd(pup_pkg::PUP_SEL_DIR, 9, m_dir[9]);
        wr(pup_pkg::PUP_SEL_DATA, 7, 8'hff);
        wr(pup_pkg::PUP_SEL_DATA, 7, 8'h00);
        // Every processor mode code entered from single-chip
        for (int c = 0; c < 4; c++) begin
            wr(pup_pkg::PUP_SEL_PM0, 0, 8'h00);
            wr(pup_pkg::PUP_SEL_PULL, 1, 8'h00);
            wr(pup_pkg::PUP_SEL_PM0, 0, c[7:0]);
            mode_chk();
            rd(pup_pkg::PUP_SEL_PULL, 1, m_pur[1]);
        end
        // Bus mode lockout; chip-select lines left as inputs
        for (int p = 0; p < 11; p++) bus_line_mask[p] = r8() & (p == 4 ? 8'h8f : 8'hff);
        wr(pup_pkg::PUP_SEL_PULL, 0, 8'hff);
        for (int p = 0; p < 11; p++) begin
            wr(pup_pkg::PUP_SEL_DIR, p, r8() & (p == 4 ? 8'h8f : 8'hff));
            wr(pup_pkg::PUP_SEL_DATA, p, r8());
            rd(pup_pkg::PUP_SEL_DIR, p, m_dir[p]);
            rd(pup_pkg::PUP_SEL_DATA, p, exp_data(p));
        end
        wr(pup_pkg::PUP_SEL_PM0, 0, 8'h83);
        rd(pup_pkg::PUP_SEL_PM0, 0, 8'h83);
        mode_chk();
        srst();
        rd(pup_pkg::PUP_SEL_PULL, 1, 8'h02);
        wr(pup_pkg::PUP_SEL_PM0, 0, 8'h00);
        srst();
        rd(pup_pkg::PUP_SEL_PULL, 1, 8'h00);
        hw(1'b1);
        mode_chk();
        rd(pup_pkg::PUP_SEL_PULL, 1, 8'h02);
        results();
    end
endmodule : tb_pup_port_ctrl
